// [inc/adc_cmd_consts.svh]
/*
 * Constants of the serial command and configuration front end:
 * frame geometry, command codes, configuration field positions,
 * multiplexer select codes and sampling lengths.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ADC_CMD_CONSTS_SVH
`define ADC_CMD_CONSTS_SVH

`define CMD_LAST 5'd3
`define FRAME_LAST 5'd15
`define ZERO_TAIL 4'h0

`define CMD_CHAN_MAX 4'h7
`define CMD_PWRDN 4'h8
`define CMD_CFG_RD 4'h9
`define CMD_CFG_WR 4'ha
`define CMD_TEST_MID 4'hb
`define CMD_TEST_LO 4'hc
`define CMD_TEST_HI 4'hd
`define CMD_FIFO_RD 4'he
`define CMD_RSVD 4'hf

`define SEL_TEST_MID 4'h8
`define SEL_TEST_LO 4'h9
`define SEL_TEST_HI 4'ha
`define SEL_RESET 4'h0

`define CFG_RESET 12'h000
`define CFG_REF_INT 11
`define CFG_REF_2V 10
`define CFG_LONG 9
`define CFG_CLK_HI 8
`define CFG_CLK_LO 7
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define CFG_SWP_HI 4
`define CFG_SWP_LO 3
`define CFG_EOC 2
`define CFG_TRIG_HI 1
`define CFG_TRIG_LO 0

`define SAMPLE_SHORT 5'd12
`define SAMPLE_LONG 5'd24

`endif

// [inc/adc_cmd_pkg.sv]
/*
 * Types of the serial command and configuration front end.
 * Assumes nothing of its surroundings.
 */
package adc_cmd_pkg;

typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_WAIT_FS = 2'b01,
    FR_ACTIVE = 2'b10,
    FR_DONE = 2'b11
} frame_st_t;

typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_SWEEP = 2'b10,
    MODE_REP_SWEEP = 2'b11
} conv_mode_t;

typedef enum logic [1:0] {
    CCLK_OSC = 2'b00,
    CCLK_SCLK = 2'b01,
    CCLK_DIV4 = 2'b10,
    CCLK_DIV2 = 2'b11
} conv_clk_t;

endpackage

// [rtl/sample_timer.sv]
/*
 * Normal sampling period timer: counts serial clock capture edges
 * after a conversion command and flags the start of conversion.
 * Assumes tick is a one-cycle pulse per capture edge on mclk.
 */
`timescale 1ns/10ps
`include "adc_cmd_consts.svh"

module sample_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic stop,
    input wire logic tick,
    input wire logic long_sel,
    output logic sampling,
    output logic conv_start
);

logic [4:0] cnt_r;
logic [4:0] len;

assign len = long_sel ? `SAMPLE_LONG : `SAMPLE_SHORT;

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        cnt_r <= 5'h00;
        sampling <= 1'b0;
        conv_start <= 1'b0;
    end
    else
    begin
        conv_start <= 1'b0;
        if (start)
        begin
            cnt_r <= 5'h00;
            sampling <= 1'b1;
        end
        else if (stop)
            sampling <= 1'b0;
        else if (sampling && tick)
        begin
            if (cnt_r == len - 5'd1)
            begin
                sampling <= 1'b0;
                conv_start <= 1'b1;
            end
            cnt_r <= cnt_r + 5'd1;
        end
    end
end

endmodule

// [rtl/adc_serial_command_config.sv]
/*
 * Serial command decoder and configuration register of a multi-input
 * successive-approximation converter, with the serial output shifter.
 * Assumes cs_n, sclk, sdi and frame_sync_in synchronous to mclk and
 * slow enough that every sclk level lasts at least one mclk cycle.
 */
`timescale 1ns/10ps
`include "adc_cmd_consts.svh"

module adc_serial_command_config #(
    parameter int NUM_INPUTS = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic frame_sync_in,
    input wire logic hw_pwdn,
    input wire logic [11:0] out_buffer,
    output logic sdo,
    output logic sdo_oe,
    output logic [11:0] converter_configuration,
    output logic [3:0] serial_command_code,
    output logic [3:0] channel_sel,
    output logic sample_start,
    output logic sampling,
    output logic conv_start,
    output logic soft_pwdn,
    output logic fifo_pop,
    output logic ref_internal,
    output logic ref_2v,
    output logic long_sample,
    output adc_cmd_pkg::conv_clk_t conv_clk_sel,
    output adc_cmd_pkg::conv_mode_t conv_mode,
    output logic [1:0] sweep_order,
    output logic eoc_pin_mode,
    output logic [1:0] fifo_threshold
);
import adc_cmd_pkg::*;

function automatic logic is_conv(input logic [3:0] c);
    if (c <= `CMD_CHAN_MAX)
        is_conv = (NUM_INPUTS == 8) || !c[0];
    else
        is_conv = (c == `CMD_TEST_MID) || (c == `CMD_TEST_LO) ||
                  (c == `CMD_TEST_HI);
endfunction

function automatic logic [3:0] chan_of(input logic [3:0] c);
    if (c <= `CMD_CHAN_MAX)
        chan_of = (NUM_INPUTS == 8) ? c : {1'b0, c[3:1]};
    else if (c == `CMD_TEST_MID)
        chan_of = `SEL_TEST_MID;
    else if (c == `CMD_TEST_LO)
        chan_of = `SEL_TEST_LO;
    else
        chan_of = `SEL_TEST_HI;
endfunction

logic cs_q, sclk_q, fs_q, dsp_r;
frame_st_t st_r;
frame_st_t st_nxt;
logic [4:0] in_cnt_r;
logic [15:0] shift_in_r;
logic [4:0] out_cnt_r;
logic [15:0] out_sr_r;
logic oe_r;
logic [11:0] cfg_r;
logic [3:0] cmd_r;
logic [3:0] chan_r;
logic pwdn_r;
logic pop_r;
logic cs_fall, sclk_rise, sclk_fall, fs_fall, cap_edge, out_edge;
logic frame_go, cap_en, out_en, cmd_done, word_done;
logic [3:0] cmd_now;
logic [11:0] cfg_data;
logic cfg_we;

// pins are synchronous, so one stage suffices for edge detection
always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        cs_q <= 1'b1;
        sclk_q <= 1'b0;
        fs_q <= 1'b1;
    end
    else
    begin
        cs_q <= cs_n;
        sclk_q <= sclk;
        fs_q <= frame_sync_in;
    end
end

assign cs_fall = cs_q & ~cs_n;
assign sclk_rise = ~sclk_q & sclk;
assign sclk_fall = sclk_q & ~sclk;
assign fs_fall = fs_q & ~frame_sync_in;
assign cap_edge = dsp_r ? sclk_fall : sclk_rise;
assign out_edge = dsp_r ? sclk_rise : sclk_fall;

// interface flavour is latched once per select low period
always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        dsp_r <= 1'b0;
    else if (cs_fall)
        dsp_r <= ~frame_sync_in;
end

always_comb
begin
    st_nxt = st_r;
    case (st_r)
        FR_IDLE:
            if (cs_fall)
                st_nxt = frame_sync_in ? FR_ACTIVE : FR_WAIT_FS;
        FR_WAIT_FS:
            if (fs_fall)
                st_nxt = FR_ACTIVE;
        FR_ACTIVE:
            if (word_done)
                st_nxt = FR_DONE;
        FR_DONE:
            if (frame_go)
                st_nxt = FR_ACTIVE;
        default:
            st_nxt = FR_IDLE;
    endcase
    if (cs_n)
        st_nxt = FR_IDLE;
end

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        st_r <= FR_IDLE;
    else
        st_r <= st_nxt;
end

// with select held low a frame sync device frames on every sync fall outside an active frame
assign frame_go = ~cs_n &&
    ((st_r == FR_IDLE && cs_fall && frame_sync_in) ||
     ((st_r == FR_WAIT_FS || st_r == FR_DONE) && dsp_r && fs_fall));
assign cap_en = ~cs_n && st_r == FR_ACTIVE && cap_edge;
assign cmd_done = cap_en && in_cnt_r == `CMD_LAST;
assign word_done = cap_en && in_cnt_r == `FRAME_LAST;
assign cmd_now = {shift_in_r[2:0], sdi};
assign cfg_data = {shift_in_r[10:0], sdi};

// counter only moves on edges, so a paused clock just waits
always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        in_cnt_r <= 5'h00;
        shift_in_r <= 16'h0000;
    end
    else if (frame_go)
        in_cnt_r <= 5'h00;
    else if (cap_en)
    begin
        shift_in_r <= {shift_in_r[14:0], sdi};
        in_cnt_r <= in_cnt_r + 5'd1;
    end
end

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        cmd_r <= `CMD_RSVD;
    else if (cmd_done)
        cmd_r <= cmd_now;
end

// blocked while powered down; a select command ends software power down first, but not hw_pwdn
assign cfg_we = word_done && cmd_r == `CMD_CFG_WR && ~hw_pwdn && ~pwdn_r;

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        cfg_r <= `CFG_RESET;
    else if (cfg_we)
        cfg_r <= cfg_data;
end

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        pwdn_r <= 1'b0;
    else if (cmd_done && cmd_now == `CMD_PWRDN)
        pwdn_r <= 1'b1;
    else if (cmd_done && is_conv(cmd_now))
        pwdn_r <= 1'b0;
end

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        chan_r <= `SEL_RESET;
    else if (cmd_done && is_conv(cmd_now))
        chan_r <= chan_of(cmd_now);
end

always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
        pop_r <= 1'b0;
    else
        pop_r <= cmd_done && cmd_now == `CMD_FIFO_RD;
end

// reserved and odd four-input codes fall through with no effect
assign sample_start = cmd_done && is_conv(cmd_now);

sample_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .start(sample_start),
    .stop(cmd_done && cmd_now == `CMD_PWRDN),
    .tick(cap_edge),
    .long_sel(cfg_r[`CFG_LONG]),
    .sampling(sampling),
    .conv_start(conv_start)
);

assign out_en = out_edge && ~cs_n && oe_r && out_cnt_r < in_cnt_r;

// buffered result is preloaded since the command is still unknown
always_ff @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        out_sr_r <= 16'h0000;
        out_cnt_r <= 5'h00;
        oe_r <= 1'b0;
    end
    else if (cs_n)
        oe_r <= 1'b0;
    else if (frame_go)
    begin
        out_sr_r <= {out_buffer, `ZERO_TAIL};
        out_cnt_r <= 5'h00;
        oe_r <= 1'b1;
    end
    else if (cmd_done && cmd_now == `CMD_CFG_RD)
        out_sr_r <= {out_sr_r[15], cfg_r, 3'b000};
    else if (out_en)
    begin
        if (out_cnt_r == `FRAME_LAST)
            oe_r <= 1'b0;
        out_sr_r <= {out_sr_r[14:0], 1'b0};
        out_cnt_r <= out_cnt_r + 5'd1;
    end
end

assign sdo = out_sr_r[15];
assign sdo_oe = oe_r;
assign converter_configuration = cfg_r;
assign serial_command_code = cmd_r;
assign channel_sel = chan_r;
assign soft_pwdn = pwdn_r;
assign fifo_pop = pop_r;
assign ref_internal = cfg_r[`CFG_REF_INT];
assign ref_2v = cfg_r[`CFG_REF_2V];
assign long_sample = cfg_r[`CFG_LONG];
assign conv_clk_sel = conv_clk_t'(cfg_r[`CFG_CLK_HI:`CFG_CLK_LO]);
assign conv_mode = conv_mode_t'(cfg_r[`CFG_MODE_HI:`CFG_MODE_LO]);
assign sweep_order = conv_mode[1] ?
    cfg_r[`CFG_SWP_HI:`CFG_SWP_LO] : 2'b00;
assign eoc_pin_mode = cfg_r[`CFG_EOC];
assign fifo_threshold = cfg_r[`CFG_TRIG_HI:`CFG_TRIG_LO];

spi_frame_a: assert property (@(posedge mclk) disable iff (rst)
    st_r == FR_IDLE && cs_fall && frame_sync_in |=>
    st_r == FR_ACTIVE && sdo_oe && !dsp_r)
    else $error("select fall did not open a frame");

dsp_frame_a: assert property (@(posedge mclk) disable iff (rst)
    st_r == FR_WAIT_FS && fs_fall && !cs_n |=> st_r == FR_ACTIVE && sdo_oe)
    else $error("sync fall did not open a frame");

cmd_latch_a: assert property (@(posedge mclk) disable iff (rst)
    cap_en && in_cnt_r == 5'd3 |=>
    serial_command_code == $past(cmd_now) && in_cnt_r == 5'd4)
    else $error("command not taken after four bits");

pwrdn_cmd_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_done && cmd_now == `CMD_PWRDN |=> soft_pwdn && !sampling)
    else $error("power down command ignored");

cfg_read_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_done && cmd_now == `CMD_CFG_RD |=> out_sr_r[14:3] == cfg_r)
    else $error("configuration not loaded for readback");

cfg_write_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_we |=> converter_configuration == $past(cfg_data))
    else $error("configuration write lost");

fifo_tail_a: assert property (@(posedge mclk) disable iff (rst)
    frame_go |=> out_sr_r[3:0] == 4'h0 && out_cnt_r == 5'd0)
    else $error("result frame tail not zero");

cfg_hold_a: assert property (@(posedge mclk) disable iff (rst)
    soft_pwdn || hw_pwdn |=> $stable(converter_configuration))
    else $error("configuration changed in power down");

sweep_gate_a: assert property (@(posedge mclk) disable iff (rst)
    conv_mode == MODE_SINGLE || conv_mode == MODE_REPEAT |-> sweep_order == 2'b00)
    else $error("sweep order active outside sweep");

sample_go_a: assert property (@(posedge mclk) disable iff (rst)
    sample_start |=> sampling ##0 serial_command_code <= `CMD_TEST_HI)
    else $error("sampling did not start");

no_sample_a: assert property (@(posedge mclk) disable iff (rst)
    cmd_done && (cmd_now == `CMD_RSVD || cmd_now == `CMD_FIFO_RD ||
    cmd_now == `CMD_CFG_WR) |-> !sample_start)
    else $error("non-select command started sampling");

sdo_idle_a: assert property (@(posedge mclk) disable iff (rst)
    cs_n |=> !sdo_oe)
    else $error("serial output driven while deselected");

sdo_release_a: assert property (@(posedge mclk) disable iff (rst)
    out_en && out_cnt_r == 5'd15 |=> !sdo_oe ##1 !sdo_oe || frame_go)
    else $error("serial output not released after bit 16");

cfg_write_c: cover property (@(posedge mclk) disable iff (rst) cfg_we);
fifo_read_c: cover property (@(posedge mclk) disable iff (rst) fifo_pop);
dsp_frame_c: cover property (@(posedge mclk) disable iff (rst)
    dsp_r && frame_go);
long_sample_c: cover property (@(posedge mclk) disable iff (rst)
    conv_start && long_sample);

endmodule

// [tb/host_port.sv]
/*
 * Host serial port model: drives select, serial clock, data and frame
 * sync for one 16-bit frame and collects what the device shifts out.
 * Assumes mclk from the bench; the bench calls frame() and reads oe_end.
 */
`timescale 1ns/10ps

module host_port (
    input wire logic mclk,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    output logic frame_sync_in
);
    logic oe_end;

    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        frame_sync_in = 1'b1;
        oe_end = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // two mclk per clock level keeps every level visible to the device
    task automatic frame(input logic [15:0] w, input bit dsp,
        input int pause, output logic [15:0] r);
        logic last;
        last = 1'b0;
        r = '0;
        @(posedge mclk);
        sclk <= dsp;
        frame_sync_in <= ~dsp;
        idle(2);
        cs_n <= 1'b0;
        if (dsp)
        begin
            idle(2);
            frame_sync_in <= 1'b1;
            idle(2);
            frame_sync_in <= 1'b0;
        end
        idle(2);
        for (int i = 15; i >= 0; i--)
        begin
            sdi <= w[i];
            if (i == 7)
                idle(pause);
            idle(2);
            sclk <= ~dsp;
            // undriven line: show the inverse so a float never matches
            r[i] = sdo_oe ? sdo : ~last;
            last = r[i];
            idle(2);
            sclk <= dsp;
        end
        idle(3);
        oe_end = sdo_oe;
        cs_n <= 1'b1;
        sdi <= ~w[0];
        frame_sync_in <= 1'b1;
        idle(3);
    endtask
endmodule

// [tb/tb.sv]
/*
 * Self-checking bench of the serial command and configuration block.
 * Assumes the host_port model on the serial side; results are judged
 * from the block's ports and a few event counters.
 */
`timescale 1ns/10ps

module tb;
    import adc_cmd_pkg::*;
    logic mclk, rst, hw_pwdn, cs_n, sclk, sdi, frame_sync_in;
    logic sdo, sdo_oe, sample_start, sampling, conv_start, soft_pwdn;
    logic fifo_pop, ref_internal, ref_2v, long_sample, eoc_pin_mode;
    logic [11:0] out_buffer, converter_configuration;
    logic [3:0] serial_command_code, channel_sel;
    logic [1:0] sweep_order, fifo_threshold;
    logic [15:0] rd;
    conv_clk_t conv_clk_sel;
    conv_mode_t conv_mode;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int starts = 0;
    int convs = 0;
    int pops = 0;

    adc_serial_command_config #(.NUM_INPUTS(8)) dut_u (
        .mclk(mclk),
        .rst(rst),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdi(sdi),
        .frame_sync_in(frame_sync_in),
        .hw_pwdn(hw_pwdn),
        .out_buffer(out_buffer),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .converter_configuration(converter_configuration),
        .serial_command_code(serial_command_code),
        .channel_sel(channel_sel),
        .sample_start(sample_start),
        .sampling(sampling),
        .conv_start(conv_start),
        .soft_pwdn(soft_pwdn),
        .fifo_pop(fifo_pop),
        .ref_internal(ref_internal),
        .ref_2v(ref_2v),
        .long_sample(long_sample),
        .conv_clk_sel(conv_clk_sel),
        .conv_mode(conv_mode),
        .sweep_order(sweep_order),
        .eoc_pin_mode(eoc_pin_mode),
        .fifo_threshold(fifo_threshold)
    );

    host_port host_u (
        .mclk(mclk),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .cs_n(cs_n),
        .sclk(sclk),
        .sdi(sdi),
        .frame_sync_in(frame_sync_in)
    );

    initial
        mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // 25 frames of under 150 cycles each fit well inside this
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (sample_start === 1'b1)
            starts <= starts + 1;
        if (conv_start === 1'b1)
            convs <= convs + 1;
        if (fifo_pop === 1'b1)
            pops <= pops + 1;
        if (cycles == 10000)
        begin
            failures = failures + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic t_reset;
        chk(converter_configuration, 16'h000);
        chk(serial_command_code, 16'hf);
        chk(sdo_oe, 16'h0);
        host_u.frame(16'ha000, 1'b0, 0, rd);
        chk(converter_configuration, 16'h000);
        chk(serial_command_code, 16'ha);
    endtask

    task automatic t_cfg_write;
        int s;
        s = starts;
        host_u.frame(16'ha94e, 1'b0, 40, rd);
        chk(converter_configuration, 16'h94e);
        chk(ref_internal, 16'h1);
        chk(ref_2v, 16'h0);
        chk(long_sample, 16'h0);
        chk(conv_clk_sel, CCLK_DIV4);
        chk(conv_mode, MODE_SWEEP);
        chk(sweep_order, 16'h1);
        chk(eoc_pin_mode, 16'h1);
        chk(fifo_threshold, 16'h2);
        chk(starts - s, 16'h0);
    endtask

    task automatic t_cfg_read_dsp;
        host_u.frame(16'h9000, 1'b1, 0, rd);
        chk(rd[11:0], 16'h94e);
        chk(serial_command_code, 16'h9);
        chk(host_u.oe_end, 16'h0);
    endtask

    task automatic t_select;
        int s;
        int c;
        logic [3:0] code;
        for (int i = 0; i < 14; i++)
        begin
            if (i > 7 && i < 11)
                continue;
            code = i[3:0];
            s = starts;
            c = convs;
            host_u.frame({code, 12'h000}, 1'b0, 0, rd);
            chk(channel_sel, (i < 8) ? code : code - 4'h3);
            chk(serial_command_code, code);
            chk(starts - s, 16'h1);
            chk(convs - c, 16'h1);
            chk(sampling, 16'h0);
            chk(rd, {out_buffer, 4'h0});
            chk(host_u.oe_end, 16'h0);
        end
    endtask

    task automatic t_pwdn;
        int s;
        s = starts;
        host_u.frame(16'h8000, 1'b0, 0, rd);
        chk(soft_pwdn, 16'h1);
        chk(starts - s, 16'h0);
        host_u.frame(16'ha123, 1'b0, 0, rd);
        chk(converter_configuration, 16'h94e);
        host_u.frame(16'h0000, 1'b0, 0, rd);
        chk(soft_pwdn, 16'h0);
        @(posedge mclk);
        hw_pwdn <= 1'b1;
        host_u.frame(16'ha123, 1'b0, 0, rd);
        chk(converter_configuration, 16'h94e);
        @(posedge mclk);
        hw_pwdn <= 1'b0;
    endtask

    task automatic t_fifo_rsvd;
        int s;
        int p;
        s = starts;
        p = pops;
        @(posedge mclk);
        out_buffer <= 12'hc35;
        host_u.frame(16'he000, 1'b0, 0, rd);
        chk(rd, 16'hc350);
        chk(pops - p, 16'h1);
        host_u.frame(16'hf5a5, 1'b0, 0, rd);
        chk(converter_configuration, 16'h94e);
        chk(starts - s, 16'h0);
    endtask

    // long sampling spans the twelve trailing clocks of one frame and the first twelve clocks of the next
    task automatic t_long;
        int c;
        host_u.frame(16'ha618, 1'b0, 0, rd);
        chk(long_sample, 16'h1);
        chk(ref_internal, 16'h0);
        chk(ref_2v, 16'h1);
        chk(conv_clk_sel, CCLK_OSC);
        chk(conv_mode, MODE_SINGLE);
        chk(sweep_order, 16'h0);
        chk(eoc_pin_mode, 16'h0);
        chk(fifo_threshold, 16'h0);
        c = convs;
        host_u.frame(16'h1000, 1'b0, 0, rd);
        chk(convs - c, 16'h0);
        chk(sampling, 16'h1);
        host_u.frame(16'hf000, 1'b0, 0, rd);
        chk(convs - c, 16'h1);
        chk(sampling, 16'h0);
        // power down in mid sampling must end it with no conversion
        c = convs;
        host_u.frame(16'h1000, 1'b0, 0, rd);
        host_u.frame(16'h8000, 1'b0, 0, rd);
        chk(sampling, 16'h0);
        chk(convs - c, 16'h0);
    endtask

    initial
    begin
        rst = 1'b1;
        hw_pwdn = 1'b0;
        out_buffer = 12'h3a7;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        t_reset();
        t_cfg_write();
        t_cfg_read_dsp();
        t_select();
        t_pwdn();
        t_fifo_rsvd();
        t_long();
        end_of_test();
    end
endmodule
